// [logic/lpm_ctrl.sv]
/*
 Low-power mode controller: status word with mode-control bits, clock and
 oscillator gating, interrupt entry and return sequencing with a small
 word stack, and an APB slave for software access.
 Assumes the core, peripherals and APB master all run on pclk, and that
 the core stalls while the cpu_run output is low.
*/
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps

module lpm_ctrl #(
   parameter int STACK_DEPTH = 16,
   parameter int PTR_WIDTH   = 4
) (
   input  wire  logic                      pclk,
   input  wire  logic                      presetn,
   input  wire  logic                      clk_en,
   input  wire  logic                      psel,
   input  wire  logic                      penable,
   input  wire  logic                      pwrite,
   input  wire  logic [7:0]                paddr,
   input  wire  logic [31:0]               pwdata,
   output       logic [31:0]               prdata,
   output       logic                      pready,
   output       logic                      pslverr,
   input  wire  logic                      irq_request,
   input  wire  logic                      nmi_request,
   input  wire  logic                      return_from_irq,
   input  wire  logic [15:0]               program_counter,
   output       lpm_pkg::lpm_gate_t        gate,
   output       logic                      isr_start,
   output       logic                      resume_valid,
   output       logic [15:0]               resume_pc
);
   import lpm_pkg::*;

   logic [15:0]           status_word;
   logic [15:0]           next_status;
   logic [3:0]            clk_source;
   logic [15:0]           stack_mem [STACK_DEPTH];
   logic [PTR_WIDTH-1:0]  stack_ptr;
   logic [PTR_WIDTH-1:0]  stack_sel;
   logic [15:0]           entry_pc;
   lpm_seq_t              seq_state;
   logic [2:0]            seq_count;
   logic                  apb_access;
   logic                  apb_write;
   logic                  apb_setup;
   logic                  wake_request;
   logic                  push_pc;
   logic                  push_sw;
   logic                  pop_sw;
   logic                  pop_pc;
   logic [PTR_WIDTH-1:0]  top_index;
   lpm_gate_t             next_gate;

   // Bus phases; pready is registered from setup, so every access completes without a wait state
   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable & pready;
   assign apb_write  = apb_access & pwrite;

   // Halted core still wakes on any enabled source
   assign wake_request = nmi_request | (irq_request & status_word[SW_GLOBAL_IRQ_ENABLE]);

   // Stack steps inside the entry and return sequences
   assign push_pc   = (seq_state == SEQ_ENTRY)  && (seq_count == PUSH_PC_CYCLE);
   assign push_sw   = (seq_state == SEQ_ENTRY)  && (seq_count == PUSH_SW_CYCLE);
   assign pop_sw    = (seq_state == SEQ_RETURN) && (seq_count == POP_SW_CYCLE);
   assign pop_pc    = (seq_state == SEQ_RETURN) && (seq_count == POP_PC_CYCLE);
   assign top_index = stack_ptr - PTR_WIDTH'(1);

   // Per-bit gating; listed modes fall out of the same equations
   function automatic lpm_gate_t gate_of(input logic [15:0] sw, input logic [3:0] src);
      logic      halt;
      logic      xdis;
      logic      gen0;
      logic      gen1;
      logic      dco_busy;
      logic      xtal_busy;
      lpm_gate_t g;
      halt = sw[SW_CPU_HALT_BIT];
      xdis = sw[SW_CRYSTAL_DISABLE_BIT];
      gen0 = sw[SW_GENERATOR_BIT_ZERO];
      gen1 = sw[SW_GENERATOR_BIT_ONE];
      // Sources still needed by a clock that is running
      dco_busy  = (src[SRC_DCO_MAIN] & ~halt) | (src[SRC_DCO_SUB] & ~gen1);
      xtal_busy = (src[SRC_XTAL_MAIN] & ~halt) | (src[SRC_XTAL_SUB] & ~gen1);
      g.cpu_run         = ~halt;
      g.main_clk_en     = ~halt;
      g.sub_main_clk_en = ~gen1;
      g.dco_osc_en      = ~(halt & (gen0 | gen1));
      g.dc_gen_en       = ~(gen0 & ~dco_busy);
      g.xtal_osc_en     = ~(xdis & ~xtal_busy);
      g.aux_clk_en      = ~xdis;
      return g;
   endfunction

   // Next status word: sequencer outranks a software write in the same cycle
   always_comb begin
      next_status = status_word;
      if (apb_write && paddr == REG_STATUS_WORD) begin
         next_status = pwdata[15:0];
      end
      if (push_sw) begin
         next_status = status_word & ~ENTRY_CLEAR_MASK;
      end else if (pop_sw) begin
         next_status = stack_mem[top_index];
      end
   end

   // Gate for the mode being entered, so outputs move on the writing edge
   assign next_gate = gate_of(next_status, clk_source);

   // Status word; written by software and the sequencer, cleared by reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= STATUS_WORD_RESET;
      end else if (clk_en) begin
         status_word <= next_status;
      end
   end

   // Registered clock and resource enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate <= lpm_gate_t'(GATE_RESET);
      end else if (clk_en) begin
         gate <= next_gate;
      end
   end

   // Clock source configuration decides which oscillators stay busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_source <= CLK_SOURCE_RESET;
      end else if (clk_en) begin
         if (apb_write && paddr == REG_CLK_SOURCE) begin
            clk_source <= pwdata[SRC_WIDTH-1:0];
         end
      end
   end

   // Stack window select for software edits of saved words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_sel <= '0;
      end else if (clk_en) begin
         if (apb_write && paddr == REG_STACK_SEL) begin
            stack_sel <= pwdata[PTR_WIDTH-1:0];
         end
      end
   end

   // Entry and return sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_state <= SEQ_RUN;
         seq_count <= '0;
         entry_pc  <= '0;
      end else if (clk_en) begin
         case (seq_state)
            SEQ_RUN: begin
               seq_count <= '0;
               // Wake has priority; a return in the same cycle is dropped
               if (wake_request) begin
                  seq_state <= SEQ_ENTRY;
                  entry_pc  <= program_counter;
                  seq_count <= 3'h1;
               end else if (return_from_irq) begin
                  seq_state <= SEQ_RETURN;
                  seq_count <= 3'h1;
               end
            end
            SEQ_ENTRY: begin
               if (seq_count == IRQ_LATENCY_CYCLES) begin
                  seq_state <= SEQ_RUN;
                  seq_count <= '0;
               end else begin
                  seq_count <= seq_count + 3'h1;
               end
            end
            SEQ_RETURN: begin
               if (seq_count == RETURN_CYCLES) begin
                  seq_state <= SEQ_RUN;
                  seq_count <= '0;
               end else begin
                  seq_count <= seq_count + 3'h1;
               end
            end
            default: begin
               seq_state <= SEQ_RUN;
               seq_count <= '0;
            end
         endcase
      end
   end

   // Service start pulse, one cycle, six cycles after acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         isr_start <= 1'b0;
      end else if (clk_en) begin
         isr_start <= (seq_state == SEQ_ENTRY) &&
                      (seq_count == IRQ_LATENCY_CYCLES - 3'h1);
      end
   end

   // Resume address from the stack, flagged for one cycle at return end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_pc    <= '0;
         resume_valid <= 1'b0;
      end else if (clk_en) begin
         if (pop_pc) begin
            resume_pc <= stack_mem[top_index];
         end
         resume_valid <= (seq_state == SEQ_RETURN) &&
                         (seq_count == RETURN_CYCLES - 3'h1);
      end
   end

   // Stack pointer; wraps on overflow, as a core stack would run over RAM
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_ptr <= '0;
      end else if (clk_en) begin
         if (push_pc || push_sw) begin
            stack_ptr <= stack_ptr + PTR_WIDTH'(1);
         end else if (pop_sw || pop_pc) begin
            stack_ptr <= stack_ptr - PTR_WIDTH'(1);
         end
      end
   end

   // Stack storage; a bus write loses to a push in the same cycle
   always_ff @(posedge pclk) begin
      if (clk_en) begin
         if (push_pc) begin
            stack_mem[stack_ptr] <= entry_pc;
         end else if (push_sw) begin
            stack_mem[stack_ptr] <= status_word;
         end else if (apb_write && paddr == REG_STACK_DATA) begin
            stack_mem[stack_sel] <= pwdata[15:0];
         end
      end
   end

   // No wait state: ready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (clk_en) begin
         pready <= apb_setup;
      end
   end

   // Read data and error, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (apb_setup) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            case (paddr)
               REG_STATUS_WORD: prdata <= {16'h0000, status_word};
               REG_CLK_SOURCE:  prdata <= {28'h0000000, clk_source};
               REG_STACK_PTR:   prdata <= 32'(stack_ptr);
               REG_STACK_SEL:   prdata <= 32'(stack_sel);
               REG_STACK_DATA:  prdata <= {16'h0000, stack_mem[stack_sel]};
               REG_GATE_STATE:  prdata <= {25'h0, gate};
               default:         pslverr <= 1'b1;
            endcase
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule // lpm_ctrl

// [logic/lpm_pkg.sv]
/*
 Package for the low-power mode controller: register map, status-word
 field positions, reset values, sequence timing and the clock-gate carrier.
 Assumes a 32-bit APB master and a core on the same pclk.
*/
// Behaviour
// - Four status-word bits select operating mode
// - All bits clear: CPU and clocks run
// - Halt only: stop CPU and main clock
// - Halt plus gen0: DIGITALLY_CONTROLLED_OSC off, DC gated when DCO feeds no running clock
// - Halt plus gen1: sub-main and DIGITALLY_CONTROLLED_OSC off
// - Halt, gen1, gen0: only auxiliary clock runs
// - All four set: every clock stops
// - Mode bit writes take effect immediately
// - Gated peripherals idle until clock returns
// - Mode changes keep pins, RAM, registers
// - Any enabled interrupt wakes every mode
// - Wake pushes program counter and status word
// - Entry clears halt, crystal disable, gen1, interrupt enable
// - Return pops status word, restoring mode
// - Edited saved word selects mode on return
// - Software reads, writes mode bits and stack
// - Crystal stops only when feeding nothing
// - Six cycles from acceptance to service
package lpm_pkg;

   // Register byte addresses
   localparam logic [7:0] REG_STATUS_WORD = 8'h00;
   localparam logic [7:0] REG_CLK_SOURCE  = 8'h04;
   localparam logic [7:0] REG_STACK_PTR   = 8'h08;
   localparam logic [7:0] REG_STACK_SEL   = 8'h0C;
   localparam logic [7:0] REG_STACK_DATA  = 8'h10;
   localparam logic [7:0] REG_GATE_STATE  = 8'h14;

   // Status word field positions
   localparam int SW_GLOBAL_IRQ_ENABLE   = 3;
   localparam int SW_CPU_HALT_BIT        = 4;
   localparam int SW_CRYSTAL_DISABLE_BIT = 5;
   localparam int SW_GENERATOR_BIT_ZERO  = 6;
   localparam int SW_GENERATOR_BIT_ONE   = 7;
   localparam int SW_WIDTH               = 16;

   // Clock source field positions
   localparam int SRC_DCO_MAIN  = 0;
   localparam int SRC_DCO_SUB   = 1;
   localparam int SRC_XTAL_MAIN = 2;
   localparam int SRC_XTAL_SUB  = 3;
   localparam int SRC_WIDTH     = 4;

   // Reset values
   localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
   localparam logic [3:0]  CLK_SOURCE_RESET  = 4'h3;

   // Bits cleared when interrupt service is entered
   localparam logic [15:0] ENTRY_CLEAR_MASK  = 16'h00B8;

   // Sequence timing in cycles
   localparam logic [2:0] IRQ_LATENCY_CYCLES = 3'h6;
   localparam logic [2:0] RETURN_CYCLES      = 3'h5;
   localparam logic [2:0] PUSH_PC_CYCLE      = 3'h1;
   localparam logic [2:0] PUSH_SW_CYCLE      = 3'h2;
   localparam logic [2:0] POP_SW_CYCLE       = 3'h1;
   localparam logic [2:0] POP_PC_CYCLE       = 3'h2;

   // Clock and resource enables
   typedef struct packed {
      logic cpu_run;
      logic main_clk_en;
      logic sub_main_clk_en;
      logic aux_clk_en;
      logic dco_osc_en;
      logic dc_gen_en;
      logic xtal_osc_en;
   } lpm_gate_t;

   localparam logic [6:0] GATE_RESET = 7'h7F;

   typedef enum {
      SEQ_RUN,
      SEQ_ENTRY,
      SEQ_RETURN
   } lpm_seq_t;

endpackage

// [sim/lpm_ctrl_properties.sv]
/*
 Port checker for the low-power mode controller.
 Assumes clk_en stays high and no status write meets a sequencer step.
*/
`timescale 1ns/1ps
module lpm_ctrl_properties (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic               pready,
   input wire logic               nmi_request,
   input wire lpm_pkg::lpm_gate_t gate,
   input wire logic               isr_start
);
   import lpm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed status write carrying mode bits m
   sequence s_mode(logic [3:0] m);
      psel && penable && pready && pwrite && paddr == REG_STATUS_WORD && pwdata[7:4] == m;
   endsequence
   sequence s_quiet;
      !isr_start [*5];
   endsequence
   property p_active; s_mode(4'h0) |=> gate == 7'h7F; endproperty
   property p_mode_zero; s_mode(4'h1) |=> gate == 7'h1F; endproperty
   // DC generator state depends on the source setting, so only the fixed bits are held
   property p_mode_one; s_mode(4'h5) |=> gate[6:2] == 5'h06 && gate[0]; endproperty
   property p_mode_two; s_mode(4'h9) |=> gate == 7'h0B; endproperty
   property p_mode_three; s_mode(4'hD) |=> gate == 7'h09; endproperty
   // Crystal feeds no running clock here, so it stops too, yet it is left out
   property p_mode_four; s_mode(4'hF) |=> gate[6:1] == 6'h00; endproperty
   property p_latency; $rose(nmi_request) |=> s_quiet ##1 isr_start; endproperty
   property p_entry; isr_start |-> gate.cpu_run && gate.sub_main_clk_en && gate.aux_clk_en; endproperty
   property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
   a_active: assert property (p_active) else $error("active gate wrong");
   a_mode_zero: assert property (p_mode_zero) else $error("mode zero gate wrong");
   a_mode_one: assert property (p_mode_one) else $error("mode one gate wrong");
   a_mode_two: assert property (p_mode_two) else $error("mode two gate wrong");
   a_mode_three: assert property (p_mode_three) else $error("mode three gate wrong");
   a_mode_four: assert property (p_mode_four) else $error("mode four gate wrong");
   a_latency: assert property (p_latency) else $error("service start late");
   a_entry: assert property (p_entry) else $error("wake bits not cleared");
   a_ready: assert property (p_ready) else $error("ready timing wrong");
endmodule // lpm_ctrl_properties

// [sim/lpm_core_model.sv]
/*
 Behavioural core: raises requests, pulses return, runs a fetch address.
 Assumes the controller on the same pclk.
*/
`timescale 1ns/1ps
module lpm_core_model #(
   parameter logic [15:0] ISR_ADDR = 16'h8000
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire lpm_pkg::lpm_gate_t gate,
   input  wire logic               isr_start,
   input  wire logic               resume_valid,
   input  wire logic [15:0]        resume_pc,
   input  wire logic               irq_cmd,
   input  wire logic               nmi_cmd,
   input  wire logic               ret_cmd,
   output      logic               irq_request,
   output      logic               nmi_request,
   output      logic               return_from_irq,
   output      logic [15:0]        program_counter
);
   import lpm_pkg::*;
   // Flags hold until service starts, as a single-source flag would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request     <= 1'b0;
         nmi_request     <= 1'b0;
         return_from_irq <= 1'b0;
      end else begin
         irq_request     <= irq_cmd | (irq_request & ~isr_start);
         nmi_request     <= nmi_cmd | (nmi_request & ~isr_start);
         return_from_irq <= ret_cmd;
      end
   end
   // Address freezes while halted, so the pushed value is predictable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) program_counter <= 16'h0100;
      else if (resume_valid) program_counter <= resume_pc;
      else if (isr_start) program_counter <= ISR_ADDR;
      else if (gate.cpu_run) program_counter <= program_counter + 16'h0002;
   end
endmodule // lpm_core_model

// [sim/lpm_ctrl_test.sv]
/*
 Self-checking bench for the low-power mode controller.
 Assumes the core model beside it; clk_en is held high.
*/
`timescale 1ns/1ps
module lpm_ctrl_test;
   import lpm_pkg::*;
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin num_errors++; $display("BAD %0t %s", $time, m); end end
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic        irq_cmd = 1'b0;
   logic        nmi_cmd = 1'b0;
   logic        ret_cmd = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, irq_request, nmi_request, return_from_irq, isr_start, resume_valid;
   logic [15:0] program_counter, resume_pc, pc_hold;
   lpm_gate_t   gate;
   int          num_errors = 0, samples_checked = 0, isr_cnt = 0, res_cnt = 0;
   // Rows: clock source, status word, expected gate
   localparam logic [31:0] SRC = 32'h0833_3333;
   localparam logic [63:0] SW  = 64'h5030_F0D0_9050_1000;
   localparam logic [63:0] GT  = 64'h1917_0009_0B1B_1F7F;

   always #50 pclk = ~pclk;
   lpm_ctrl lpm_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_request(irq_request), .nmi_request(nmi_request), .return_from_irq(return_from_irq),
      .program_counter(program_counter), .gate(gate), .isr_start(isr_start), .resume_valid(resume_valid),
      .resume_pc(resume_pc));
   lpm_core_model lpm_core_model_inst (.pclk(pclk), .presetn(presetn), .gate(gate), .isr_start(isr_start),
      .resume_valid(resume_valid), .resume_pc(resume_pc), .irq_cmd(irq_cmd), .nmi_cmd(nmi_cmd),
      .ret_cmd(ret_cmd), .irq_request(irq_request), .nmi_request(nmi_request),
      .return_from_irq(return_from_irq), .program_counter(program_counter));
   // Pulses are counted off the edge so the count never races the flop
   always @(negedge pclk) begin
      if (isr_start === 1'b1) isr_cnt++;
      if (resume_valid === 1'b1) res_cnt++;
   end
   // One APB transfer; request held until pready is sampled high at a rising edge,
   // data taken at that edge, then a half cycle so callers see settled outputs
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      `CHK(n < 20, 1'b1, "no ready")
      @(negedge pclk);
   endtask
   task kick(input logic [2:0] k);
      @(posedge pclk);
      {irq_cmd, nmi_cmd, ret_cmd} <= k;
      @(posedge pclk);
      {irq_cmd, nmi_cmd, ret_cmd} <= 3'h0;
   endtask
   task await(input logic isr);
      int n, c0;
      n = 0;
      c0 = isr ? isr_cnt : res_cnt;
      while ((isr ? isr_cnt : res_cnt) == c0 && n < 40) begin
         @(negedge pclk);
         n++;
      end
      `CHK(n < 40, 1'b1, "pulse missing")
   endtask
   task t_reset;
      @(negedge pclk);
      `CHK(gate, GATE_RESET, "gate reset")
      apb(1'b0, REG_CLK_SOURCE, 32'h0);
      `CHK(rd, 32'h3, "source reset")
      $display("t_reset done");
   endtask
   task t_modes;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, REG_CLK_SOURCE, 32'(SRC[4*i +: 4]));
         apb(1'b1, REG_STATUS_WORD, 32'(SW[8*i +: 8]));
         `CHK(gate, GT[8*i +: 7], "gate port")
         apb(1'b0, REG_GATE_STATE, 32'h0);
         `CHK(rd, 32'(GT[8*i +: 7]), "gate reg")
         apb(1'b0, REG_CLK_SOURCE, 32'h0);
         `CHK(rd, 32'(SRC[4*i +: 4]), "source kept")
      end
      apb(1'b1, REG_STATUS_WORD, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      `CHK(err, 1'b1, "unmapped")
      $display("t_modes done");
   endtask
   // Masked request must wait; saved word is edited before return
   task t_wake;
      apb(1'b1, REG_CLK_SOURCE, 32'h3);
      apb(1'b1, REG_STATUS_WORD, 32'hD0);
      kick(3'h4);
      repeat (20) @(negedge pclk);
      `CHK(isr_cnt, 0, "masked wake")
      pc_hold = program_counter;
      apb(1'b1, REG_STATUS_WORD, 32'hD8);
      await(1'b1);
      apb(1'b0, REG_STATUS_WORD, 32'h0);
      `CHK(rd, 32'h40, "entry clear")
      apb(1'b0, REG_STACK_PTR, 32'h0);
      `CHK(rd, 32'h2, "stack depth")
      apb(1'b1, REG_STACK_SEL, 32'h0);
      apb(1'b0, REG_STACK_DATA, 32'h0);
      `CHK(rd, {16'h0, pc_hold}, "pushed pc")
      apb(1'b1, REG_STACK_SEL, 32'h1);
      apb(1'b0, REG_STACK_DATA, 32'h0);
      `CHK(rd, 32'hD8, "pushed word")
      apb(1'b1, REG_STACK_DATA, 32'h18);
      kick(3'h1);
      await(1'b0);
      `CHK(resume_pc, pc_hold, "resume pc")
      `CHK(gate, 7'h1F, "edited mode")
      $display("t_wake done");
   endtask
   task t_nmi;
      apb(1'b1, REG_STATUS_WORD, 32'hF0);
      kick(3'h2);
      await(1'b1);
      kick(3'h1);
      await(1'b0);
      `CHK(gate, 7'h00, "mode restored")
      apb(1'b0, REG_STACK_PTR, 32'h0);
      `CHK(rd, 32'h0, "stack empty")
      $display("t_nmi done");
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_modes;
      t_wake;
      t_nmi;
      give_verdict;
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(100 * 5000);
      num_errors++;
      give_verdict;
   end
endmodule // lpm_ctrl_test

bind lpm_ctrl lpm_ctrl_properties lpm_ctrl_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .nmi_request(nmi_request), .gate(gate), .isr_start(isr_start));
